/* File: dv/sfs_far_end.sv */
/*
  Far-side model: one writer and one reader pulsing their port clocks.
  Assumes callers let each task finish; clocks stand still between calls.
  Pins move by non-blocking assignment just after rising edges of mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module sfs_far_end
(
  // Bench clock the pins are stepped on
  input wire logic    mclk,
  // Write port
  output logic        wclk,
  output logic        write_enable_n,
  output logic        second_write_enable,
  output logic [17:0] write_data_in,
  // Read port
  output logic        rclk,
  output logic        read_enable_n,
  output logic        second_read_enable,
  output logic        output_enable_n
);
  initial
  begin
    {wclk, write_enable_n, second_write_enable, write_data_in} = {3'b010, 18'h0};
    {rclk, read_enable_n, second_read_enable, output_enable_n} = 4'b0100;
  end

  // One write-clock period of 168 ns (21 mclk) back to back; en low gives a clock with no write
  task automatic wr(input logic [17:0] d, input logic en, input logic en2);
  begin
    @(posedge mclk);
    write_enable_n <= ~en;
    second_write_enable <= en2;
    write_data_in <= d;
    repeat (10) @(posedge mclk);
    wclk <= 1'b1;
    repeat (10) @(posedge mclk);
    wclk <= 1'b0;
    write_enable_n <= 1'b1;
    write_data_in <= ~d; // Released data must not pass for the last word
  end
  endtask

  task automatic rd(input logic en, input logic en2);
  begin
    @(posedge mclk);
    read_enable_n <= ~en;
    second_read_enable <= en2;
    repeat (10) @(posedge mclk);
    rclk <= 1'b1;
    repeat (10) @(posedge mclk);
    rclk <= 1'b0;
    read_enable_n <= 1'b1;
  end
  endtask

  task automatic set_oe(input logic off);
  begin
    @(posedge mclk);
    output_enable_n <= off;
  end
  endtask
endmodule // sfs_far_end

`default_nettype wire

/* File: dv/sfs_flags_properties.sv */
/*
  Checker for the FIFO status-flag block, bound to its top module.
  Assumes the port clocks are slow pins held at least 4 mclk each level.
*/
`timescale 1ns/10ps
`default_nettype none

module sfs_flags_chk
#(
  parameter WIDTH = 18
)
(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             srst,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  // Port clocks and read port
  input wire logic             wclk,
  input wire logic             rclk,
  input wire logic             read_enable_n,
  input wire logic             second_read_enable,
  input wire logic             output_enable_n,
  input wire logic [WIDTH-1:0] read_data_out,
  input wire logic [WIDTH-1:0] read_data_oe,
  // Flags
  input wire logic             full_flag_n,
  input wire logic             empty_flag_n,
  input wire logic             delayed_empty_flag_n
);
  logic [7:0] ctrl_q;
  logic       dual;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // Shadow of the control word, so mode-bound checks know the mode
  always @(posedge mclk)
  begin
    if (srst)
      ctrl_q <= 8'h00;
    else if (psel && penable && pwrite && paddr == 12'h000)
      ctrl_q <= pwdata[7:0];
  end
  assign dual = ctrl_q[7] & ctrl_q[6];

  sequence read_idle;
    read_enable_n [*6];
  endsequence
  sequence dual_en2_off;
    (dual && !second_read_enable) [*6];
  endsequence
  sequence dual_oe_off;
    (dual && ctrl_q[5] && output_enable_n) [*6];
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  full_on_wclk_a: assert property (
    $changed(full_flag_n) |-> wclk && $past(wclk, 2)) else $error("full flag moved off wclk");
  empty_on_rclk_a: assert property (
    $changed(empty_flag_n) |-> rclk && $past(rclk, 2)) else $error("empty flag moved off rclk");
  empty_hold_a: assert property (
    !empty_flag_n |=> $stable(read_data_out)) else $error("output changed while empty");
  idle_hold_a: assert property (
    read_idle |=> $stable(read_data_out)) else $error("output changed with read disabled");
  en2_gate_a: assert property (
    dual_en2_off |=> $stable(read_data_out)) else $error("read taken with second enable off");
  oe_gate_a: assert property (
    dual_oe_off |=> $stable(read_data_out)) else $error("read taken with outputs off");
  dly_lag_a: assert property (
    dual && $rose(empty_flag_n) |-> !delayed_empty_flag_n) else $error("delayed empty not lagging");
  dly_follow_a: assert property (
    dual && $rose(delayed_empty_flag_n) |-> $past(empty_flag_n, 2)) else $error("delayed empty early");
  oe_off_a: assert property (
    output_enable_n [*5] |-> read_data_oe == '0) else $error("outputs driven while disabled");
  oe_on_a: assert property (
    (!output_enable_n) [*5] |-> &read_data_oe) else $error("outputs floating while enabled");
endmodule // sfs_flags_chk

bind sfs_fifo_flags sfs_flags_chk #(.WIDTH(WIDTH)) chk
(
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .wclk(wclk), .rclk(rclk),
  .read_enable_n(read_enable_n), .second_read_enable(second_read_enable),
  .output_enable_n(output_enable_n), .read_data_out(read_data_out),
  .read_data_oe(read_data_oe), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
  .delayed_empty_flag_n(delayed_empty_flag_n)
);

`default_nettype wire

/* File: dv/test_sync_fifo_status_flags.sv */
/*
  Self-checking bench for the FIFO status-flag block, built 256 words deep.
  Assumes the far-end model drives the port pins and APB answers within 40 cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module test_sync_fifo_status_flags;
  localparam int D = 256;
  localparam int O = 127;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] r;
  logic        e;
  int          mismatches = 0;
  int          check_count = 0;
  int          n;
  wire  [31:0] prdata;
  wire  [17:0] write_data_in, read_data_out, read_data_oe;
  wire         pready, pslverr, wclk, write_enable_n, second_write_enable, rclk;
  wire         read_enable_n, second_read_enable, output_enable_n, irq;
  wire         full_flag_n, almost_full_flag_n, half_full_flag_n;
  wire         almost_empty_flag_n, empty_flag_n, delayed_empty_flag_n;
  wire  [5:0]  flags = {full_flag_n, almost_full_flag_n, half_full_flag_n,
                        almost_empty_flag_n, empty_flag_n, delayed_empty_flag_n};

  always #4 mclk = ~mclk;

  sfs_fifo_flags #(.DEPTH(D), .AW(8)) uut
  (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wclk(wclk), .write_enable_n(write_enable_n), .second_write_enable(second_write_enable),
    .write_data_in(write_data_in), .rclk(rclk), .read_enable_n(read_enable_n),
    .second_read_enable(second_read_enable), .output_enable_n(output_enable_n),
    .read_data_out(read_data_out), .read_data_oe(read_data_oe), .full_flag_n(full_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .empty_flag_n(empty_flag_n),
    .delayed_empty_flag_n(delayed_empty_flag_n), .irq(irq)
  );

  sfs_far_end far
  (
    .mclk(mclk),
    .wclk(wclk), .write_enable_n(write_enable_n), .second_write_enable(second_write_enable),
    .write_data_in(write_data_in), .rclk(rclk), .read_enable_n(read_enable_n),
    .second_read_enable(second_read_enable), .output_enable_n(output_enable_n)
  );

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [17:0] pat(input int i);
    return 18'h2a5a5 ^ 18'(i * 3);
  endfunction

  task automatic print_verdict;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // The answer is taken at the rising edge that samples pready high, and only
  // then is the request released; ends half a cycle later so callers see settled outputs
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
  begin
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k == 40)
      begin
        mismatches++;
        print_verdict();
      end
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge mclk);
  end
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
  begin
    apb(1'b0, a, 32'h0);
    chk(what, exp, r);
  end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rdchk("ctrl", 12'h000, 32'h0);
    rdchk("af offset", 12'h004, 32'h7f);
    rdchk("ae offset", 12'h008, 32'h7f);
    rdchk("unmapped", 12'h01c, 32'h0);
    chk("unmapped err", 32'h1, e);
    chk("reset flags", 32'h38, flags);
    far.rd(1'b1, 1'b1);
    chk("held word", 32'h0, read_data_out);
    for (n = 1; n <= D; n++)
    begin
      far.wr(pat(n), 1'b1, 1'b1);
      chk("af hf ae", {n < D - O, n <= D / 2, n > O}, flags[4:2]);
    end
    far.wr(18'h0, 1'b0, 1'b1);
    chk("full", 32'h0, full_flag_n);
    far.wr(18'h3ffff, 1'b1, 1'b1);
    rdchk("level", 12'h018, D);
    far.rd(1'b0, 1'b1);
    chk("empty", 32'h1, empty_flag_n);
    for (n = 1; n <= D; n++)
    begin
      far.rd(1'b1, 1'b1);
      chk("word", pat(n), read_data_out);
    end
    far.rd(1'b0, 1'b1);
    far.rd(1'b1, 1'b1);
    chk("empty held", pat(D), read_data_out);
    far.wr(18'h0, 1'b0, 1'b1);
    chk("drained flags", 32'h38, flags);
    rdchk("irq stat", 12'h010, 32'hf);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, 12'h014, 32'h8);
    chk("irq on", 32'h1, irq);
    apb(1'b1, 12'h010, 32'hf);
    chk("irq cleared", 32'h0, irq);
    rdchk("irq stat", 12'h010, 32'h0);
    apb(1'b1, 12'h000, 32'he0);
    rdchk("ctrl", 12'h000, 32'he0);
    far.set_oe(1'b1);
    far.wr(18'h01234, 1'b1, 1'b1);
    far.wr(18'h00abc, 1'b1, 1'b0);
    rdchk("level", 12'h018, 32'h1);
    far.rd(1'b0, 1'b1);
    chk("empty dly", 32'h2, flags[1:0]);
    far.rd(1'b0, 1'b1);
    chk("empty dly", 32'h3, flags[1:0]);
    far.rd(1'b1, 1'b1);
    chk("oe gated", pat(D), read_data_out);
    chk("oe off", 32'h0, read_data_oe);
    far.set_oe(1'b0);
    far.rd(1'b1, 1'b0);
    chk("en2 gated", pat(D), read_data_out);
    far.rd(1'b1, 1'b1);
    chk("word", 32'h1234, read_data_out);
    chk("oe on", 32'h3ffff, read_data_oe);
    // Enhanced mode with port-timed almost flags: they move only on their own port edge
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'hff);
    apb(1'b1, 12'h000, 32'h96);
    far.wr(18'h00055, 1'b1, 1'b1);
    chk("synced flags", 32'h6, flags[4:2]);
    far.rd(1'b0, 1'b1);
    chk("synced flags", 32'h7, flags[4:2]);
    far.wr(18'h0, 1'b0, 1'b1);
    chk("synced flags", 32'h3, flags[4:2]);
    print_verdict();
  end
endmodule // test_sync_fifo_status_flags

`default_nettype wire

/* File: hw/sfs_defines.vh */
/*
  Constants for the synchronous FIFO status-flag block: register map,
  field positions, reset values and capacity figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SFS_REG_CTRL      12'h000
`define SFS_REG_PAF_OFS   12'h004
`define SFS_REG_PAE_OFS   12'h008
`define SFS_REG_STATUS    12'h00c
`define SFS_REG_IRQ_STAT  12'h010
`define SFS_REG_IRQ_MASK  12'h014
`define SFS_REG_LEVEL     12'h018

// ****************************************
// Control bits
// ****************************************
`define SFS_CTRL_PAE_SYNC 1
`define SFS_CTRL_HF_SYNC  2
`define SFS_CTRL_HF_RCLK  3
`define SFS_CTRL_PAF_SYNC 4
`define SFS_CTRL_OE_GATE  5
`define SFS_CTRL_DUAL_EN  6
`define SFS_CTRL_ENHANCED 7
`define SFS_CTRL_RST      8'h00

// ****************************************
// Offsets and capacity
// ****************************************
`define SFS_OFS_DEFAULT   13'h007f
`define SFS_DEPTH         4096
`define SFS_DEPTH_LOG2    12

// ****************************************
// Interrupt status bits
// ****************************************
`define SFS_IRQ_FULL      0
`define SFS_IRQ_EMPTY     1
`define SFS_IRQ_HALF      2
`define SFS_IRQ_OVERRUN   3
`define SFS_IRQ_W         4

`endif

/* File: hw/sfs_fifo_flags.v */
/*
  Synchronous FIFO with status flags, enable combining and a three-state
  18-bit read port, plus an APB register slave and a level interrupt.
  Assumes wclk and rclk are slow pin clocks sampled by mclk (much faster),
  and that all pin inputs are asynchronous to mclk.
*/
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sfs_defines.vh"

module sfs_fifo_flags
#(
  parameter WIDTH = 18,
  parameter DEPTH = `SFS_DEPTH,
  parameter AW    = `SFS_DEPTH_LOG2
)
(
  // Clock and reset
  input  wire             mclk,
  input  wire             srst,
  // APB slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // Write port pins
  input  wire             wclk,
  input  wire             write_enable_n,
  input  wire             second_write_enable,
  input  wire [WIDTH-1:0] write_data_in,
  // Read port pins
  input  wire             rclk,
  input  wire             read_enable_n,
  input  wire             second_read_enable,
  input  wire             output_enable_n,
  output reg  [WIDTH-1:0] read_data_out,
  output wire [WIDTH-1:0] read_data_oe,
  // Flags
  output reg              full_flag_n,
  output wire             almost_full_flag_n,
  output wire             half_full_flag_n,
  output wire             almost_empty_flag_n,
  output reg              empty_flag_n,
  output reg              delayed_empty_flag_n,
  // Interrupt
  output wire             irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire wclk_rise;
  wire rclk_rise;
  wire wen_n_s;
  wire wen2_s;
  wire ren_n_s;
  wire second_read_enable_s;
  wire oe_n_s;
  reg  [WIDTH-1:0] wdata_m_q;
  reg  [WIDTH-1:0] wdata_s_q;

  sfs_pin_sync u_wclk (.mclk(mclk), .srst(srst), .pin_in(wclk), .level(), .rise(wclk_rise));
  sfs_pin_sync u_rclk (.mclk(mclk), .srst(srst), .pin_in(rclk), .level(), .rise(rclk_rise));
  sfs_pin_sync u_wen  (.mclk(mclk), .srst(srst), .pin_in(write_enable_n), .level(wen_n_s),
                       .rise());
  sfs_pin_sync u_wen2 (.mclk(mclk), .srst(srst), .pin_in(second_write_enable), .level(wen2_s),
                       .rise());
  sfs_pin_sync u_ren  (.mclk(mclk), .srst(srst), .pin_in(read_enable_n), .level(ren_n_s),
                       .rise());
  sfs_pin_sync u_second_read_enable (.mclk(mclk), .srst(srst), .pin_in(second_read_enable), .level(second_read_enable_s),
                       .rise());
  sfs_pin_sync u_oe   (.mclk(mclk), .srst(srst), .pin_in(output_enable_n), .level(oe_n_s),
                       .rise());

  // Data bus is only used on a write-clock edge, well after it settled
  always @(posedge mclk)
  begin
    if (srst)
    begin
      wdata_m_q <= {WIDTH{1'b0}};
      wdata_s_q <= {WIDTH{1'b0}};
    end
    else
    begin
      wdata_m_q <= write_data_in;
      wdata_s_q <= wdata_m_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0]    ctrl_q;
  reg [AW:0]   paf_ofs_q;
  reg [AW:0]   pae_ofs_q;
  reg [`SFS_IRQ_W-1:0] irq_stat_q;
  reg [`SFS_IRQ_W-1:0] irq_mask_q;

  // Offset reset value cut to the register width on purpose
  localparam [12:0] OFS_RST = `SFS_OFS_DEFAULT;

  wire enh      = ctrl_q[`SFS_CTRL_ENHANCED];
  wire dual_en  = enh & ctrl_q[`SFS_CTRL_DUAL_EN];

  // ****************************************
  // Enable combining
  // ****************************************
  // Active-low pins inverted first so every term reads as "enabled"
  wire wen_act  = ~wen_n_s;
  wire ren_act  = ~ren_n_s;
  wire oe_act   = ~oe_n_s;
  wire wen_eff  = wen_act & (~dual_en | wen2_s);
  wire ren_eff  = ren_act & (~dual_en | second_read_enable_s)
                & (~(dual_en & ctrl_q[`SFS_CTRL_OE_GATE]) | oe_act);

  // ****************************************
  // Storage and occupancy
  // ****************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  reg [AW:0]      count_q;

  wire do_write = wclk_rise & wen_eff & full_flag_n;
  wire do_read  = rclk_rise & ren_eff & empty_flag_n;
  wire overrun  = wclk_rise & wen_eff & ~full_flag_n;

  // Occupancy after this cycle: a port's own edge must already see the word it
  // moved, otherwise a write on the next edge could slip past a full store
  reg [AW:0] count_d;

  always @*
  begin
    case ({do_write, do_read})
      2'b10:   count_d = count_q + 1'b1;
      2'b01:   count_d = count_q - 1'b1;
      default: count_d = count_q;
    endcase
  end

  wire is_full  = (count_d == DEPTH[AW:0]);
  wire is_empty = (count_d == {(AW+1){1'b0}});

  always @(posedge mclk)
  begin
    if (do_write)
      mem[wptr_q] <= wdata_s_q;
  end

  always @(posedge mclk)
  begin
    if (srst)
    begin
      wptr_q        <= {AW{1'b0}};
      rptr_q        <= {AW{1'b0}};
      count_q       <= {(AW+1){1'b0}};
      read_data_out <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_write)
        wptr_q <= wptr_q + 1'b1;
      if (do_read)
      begin
        rptr_q        <= rptr_q + 1'b1;
        read_data_out <= mem[rptr_q];
      end
      // Completed writes minus completed reads
      count_q <= count_d;
    end
  end

  // Three-state data bus: enable follows the output-enable pin
  assign read_data_oe = {WIDTH{oe_act}};

  // ****************************************
  // Flag comparisons
  // ****************************************
  function flag_low_at_or_above;
    input [AW:0] lvl;
    input [AW:0] thresh;
    begin
      flag_low_at_or_above = (lvl >= thresh);
    end
  endfunction

  wire paf_raw = ~flag_low_at_or_above(count_q, DEPTH[AW:0] - paf_ofs_q);
  wire hf_raw  = ~flag_low_at_or_above(count_q, DEPTH[AW:0] / 2 + 1'b1);
  wire pae_raw = flag_low_at_or_above(count_q, pae_ofs_q + 1'b1);

  reg paf_w_q;
  reg hf_w_q;
  reg hf_r_q;
  reg pae_r_q;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      full_flag_n          <= 1'b1;
      empty_flag_n         <= 1'b0;
      delayed_empty_flag_n <= 1'b0;
      paf_w_q              <= 1'b1;
      hf_w_q               <= 1'b1;
      hf_r_q               <= 1'b1;
      pae_r_q              <= 1'b0;
    end
    else
    begin
      // Flags move only on the clock edge of their own port
      if (wclk_rise)
      begin
        full_flag_n <= ~is_full;
        paf_w_q     <= paf_raw;
        hf_w_q      <= hf_raw;
      end
      if (rclk_rise)
      begin
        empty_flag_n <= ~is_empty;
        // In dual-enable mode one full read cycle behind the empty flag; otherwise it moves with it
        delayed_empty_flag_n <= dual_en ? empty_flag_n : ~is_empty;
        hf_r_q       <= hf_raw;
        pae_r_q      <= pae_raw;
      end
    end
  end

  assign almost_full_flag_n  = (enh & ctrl_q[`SFS_CTRL_PAF_SYNC]) ? paf_w_q : paf_raw;
  assign half_full_flag_n    = (enh & ctrl_q[`SFS_CTRL_HF_SYNC])
                             ? (ctrl_q[`SFS_CTRL_HF_RCLK] ? hf_r_q : hf_w_q) : hf_raw;
  assign almost_empty_flag_n = (enh & ctrl_q[`SFS_CTRL_PAE_SYNC]) ? pae_r_q : pae_raw;

  // ****************************************
  // Interrupt events
  // ****************************************
  reg full_prev_q;
  reg empty_prev_q;
  reg hf_prev_q;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      full_prev_q  <= 1'b1;
      empty_prev_q <= 1'b0;
      hf_prev_q    <= 1'b1;
    end
    else
    begin
      full_prev_q  <= full_flag_n;
      empty_prev_q <= empty_flag_n;
      hf_prev_q    <= half_full_flag_n;
    end
  end

  wire [`SFS_IRQ_W-1:0] irq_ev;
  assign irq_ev[`SFS_IRQ_FULL]    = full_prev_q & ~full_flag_n;
  assign irq_ev[`SFS_IRQ_EMPTY]   = empty_prev_q & ~empty_flag_n;
  assign irq_ev[`SFS_IRQ_HALF]    = hf_prev_q & ~half_full_flag_n;
  assign irq_ev[`SFS_IRQ_OVERRUN] = overrun;

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states: every access completes in its first access cycle
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire mapped = (paddr == `SFS_REG_CTRL)    | (paddr == `SFS_REG_PAF_OFS)
              | (paddr == `SFS_REG_PAE_OFS) | (paddr == `SFS_REG_STATUS)
              | (paddr == `SFS_REG_IRQ_STAT) | (paddr == `SFS_REG_IRQ_MASK)
              | (paddr == `SFS_REG_LEVEL);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_q     <= `SFS_CTRL_RST;
      paf_ofs_q  <= OFS_RST[AW:0];
      pae_ofs_q  <= OFS_RST[AW:0];
      irq_stat_q <= {`SFS_IRQ_W{1'b0}};
      irq_mask_q <= {`SFS_IRQ_W{1'b0}};
    end
    else
    begin
      if (apb_wr && paddr == `SFS_REG_CTRL)
        ctrl_q <= pwdata[7:0];
      if (apb_wr && paddr == `SFS_REG_PAF_OFS)
        paf_ofs_q <= pwdata[AW:0];
      if (apb_wr && paddr == `SFS_REG_PAE_OFS)
        pae_ofs_q <= pwdata[AW:0];
      if (apb_wr && paddr == `SFS_REG_IRQ_MASK)
        irq_mask_q <= pwdata[`SFS_IRQ_W-1:0];
      // A new event wins over a write-one clear in the same cycle
      if (apb_wr && paddr == `SFS_REG_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~pwdata[`SFS_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always @*
  begin
    prdata = 32'h00000000;
    if (apb_rd)
    begin
      case (paddr)
        `SFS_REG_CTRL:     prdata[7:0] = ctrl_q;
        `SFS_REG_PAF_OFS:  prdata[AW:0] = paf_ofs_q;
        `SFS_REG_PAE_OFS:  prdata[AW:0] = pae_ofs_q;
        `SFS_REG_STATUS:   prdata[5:0] = {delayed_empty_flag_n, empty_flag_n,
                                          almost_empty_flag_n, half_full_flag_n,
                                          almost_full_flag_n, full_flag_n};
        `SFS_REG_IRQ_STAT: prdata[`SFS_IRQ_W-1:0] = irq_stat_q;
        `SFS_REG_IRQ_MASK: prdata[`SFS_IRQ_W-1:0] = irq_mask_q;
        `SFS_REG_LEVEL:    prdata[AW:0] = count_q;
        default:           prdata = 32'h00000000;
      endcase
    end
  end

endmodule // sfs_fifo_flags

`default_nettype wire

/* File: hw/sfs_pin_sync.v */
/*
  Two-flop synchroniser with a rising-edge pulse from the second stage.
  Assumes the input is asynchronous to mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module sfs_pin_sync
(
  // Clock and reset
  input  wire        mclk,
  input  wire        srst,
  // Pin side
  input  wire        pin_in,
  // Synchronised outputs
  output wire        level,
  output wire        rise
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;

endmodule // sfs_pin_sync

`default_nettype wire
